// ---- pkg/frt_consts.svh ----
// Register offsets, bit positions, reset values and divider masks
`ifndef FRT_CONSTS_SVH
`define FRT_CONSTS_SVH
`define FRT_OFS_IRQ_EN      8'h10
`define FRT_OFS_CTRL_STAT   8'h11
`define FRT_OFS_CLK_EDGE    8'h16
`define FRT_RST_IRQ_EN      8'h01
`define FRT_RST_CTRL_STAT   8'h00
`define FRT_RST_CLK_EDGE    8'h00
`define FRT_BIT_CAPTURE     7
`define FRT_BIT_MATCH_A     3
`define FRT_BIT_MATCH_B     2
`define FRT_BIT_WRAP        1
`define FRT_BIT_CLR_A       0
`define FRT_BIT_FIXED_ONE   0
`define FRT_BIT_EDGE_SEL    7
`define FRT_BIT_CKS_HI      1
`define FRT_BIT_CKS_LO      0
`define FRT_DIV8_MASK       7'h07
`define FRT_DIV32_MASK      7'h1f
`define FRT_DIV128_MASK     7'h7f
`define FRT_CNT_MAX         16'hffff
`define FRT_CNT_ZERO        16'h0000
`endif

// ---- pkg/frt_pkg.sv ----
// Types shared by the timer control and status block
package frt_pkg;
    // Counter source selection
    typedef enum logic [1:0] {
        FRT_SRC_DIV8   = 2'b00,
        FRT_SRC_DIV32  = 2'b01,
        FRT_SRC_DIV128 = 2'b10,
        FRT_SRC_EXT    = 2'b11
    } frt_src_t;
    // Four interrupt requests, highest priority first
    typedef struct packed {
        logic capture;
        logic match_a;
        logic match_b;
        logic wrap;
    } frt_irq_t;
endpackage : frt_pkg

// ---- rtl/frt_ctrl.sv ----
// Free-running timer: control, status, counter and interrupt requests
`timescale 1ns/10ps
`include "frt_consts.svh"

module frt_ctrl #(
    parameter int CNT_W = 16
) (
    // Clock and resets
    input  wire logic                 CLOCK,
    input  wire logic                 SRST,
    input  wire logic                 STANDBY,
    input  wire logic                 MODULE_STANDBY,
    // Byte-wide register port
    input  wire logic [7:0]           ADDR,
    input  wire logic                 WR_EN,
    input  wire logic                 RD_EN,
    input  wire logic [7:0]           WDATA,
    output logic      [7:0]           RDATA,
    // Compare values from the datapath
    input  wire logic [CNT_W-1:0]     COMPARE_A_VALUE,
    input  wire logic [CNT_W-1:0]     COMPARE_B_VALUE,
    // Pins
    input  wire logic                 CAPTURE_INPUT_PIN,
    input  wire logic                 EXT_COUNT_PIN,
    // Counter and capture results
    output logic      [CNT_W-1:0]     UP_COUNTER,
    output logic      [CNT_W-1:0]     CAPTURE_VALUE,
    output logic                      CAPTURE_STROBE,
    // Requests to the interrupt controller
    output frt_pkg::frt_irq_t         IRQ
);

    // Width check: flag and wrap logic assume a 16-bit counter
    if (CNT_W != 16)
    begin : g_bad_width
        $error("frt_ctrl: CNT_W must be 16");
    end

    ////////////////////////////////////////////////////////////////
    // Functions
    ////////////////////////////////////////////////////////////////

    // Internal tick when the prescaler low bits are all ones
    function automatic logic div_tick(input logic [6:0] p,
                                      input logic [6:0] m);
        div_tick = ((p & m) == m);
    endfunction : div_tick

    ////////////////////////////////////////////////////////////////
    // State
    ////////////////////////////////////////////////////////////////

    logic              rst_any;          // Reset, standby or module off
    logic [3:0]        en_ff;            // Capture, A, B, wrap enables
    logic [3:0]        nxt_en;
    logic [3:0]        flag_ff;          // Capture, A, B, wrap flags
    logic [3:0]        nxt_flag;
    logic [3:0]        armed_ff;         // Flag was read while set
    logic [3:0]        nxt_armed;
    logic              clr_a_ff;         // Clear on match A
    logic              nxt_clr_a;
    logic              edge_ff;          // Capture edge select
    logic              nxt_edge;
    frt_pkg::frt_src_t src_ff;           // Counter source
    frt_pkg::frt_src_t nxt_src;
    logic [6:0]        presc_ff;         // Peripheral clock prescaler
    logic [6:0]        nxt_presc;
    logic              ext_q_ff;         // Last external count level
    logic              cap_q_ff;         // Last capture pin level
    logic [CNT_W-1:0]  cnt_ff;
    logic [CNT_W-1:0]  nxt_cnt;
    logic [CNT_W-1:0]  cap_ff;
    logic [CNT_W-1:0]  nxt_cap;
    logic              strobe_ff;
    logic [7:0]        rdata_ff;
    logic [7:0]        nxt_rdata;

    // Events of this cycle
    logic              tick;
    logic              hit_a;
    logic              hit_b;
    logic              cap_evt;
    logic              wrap_evt;
    logic              clr_now;
    logic [3:0]        set_evt;
    logic [7:0]        en_view;
    logic [7:0]        stat_view;
    logic [7:0]        ce_view;
    logic              wr_stat;

    assign rst_any = SRST | STANDBY | MODULE_STANDBY;

    ////////////////////////////////////////////////////////////////
    // Counter source, counter and events
    ////////////////////////////////////////////////////////////////

    // Tick from the chosen source
    always_comb
    begin
        nxt_presc = presc_ff + 7'h01;
        unique case (src_ff)
            frt_pkg::FRT_SRC_DIV8:
                tick = div_tick(presc_ff, `FRT_DIV8_MASK);
            frt_pkg::FRT_SRC_DIV32:
                tick = div_tick(presc_ff, `FRT_DIV32_MASK);
            frt_pkg::FRT_SRC_DIV128:
                tick = div_tick(presc_ff, `FRT_DIV128_MASK);
            frt_pkg::FRT_SRC_EXT:
                tick = EXT_COUNT_PIN & ~ext_q_ff;
        endcase
    end

    // Match is taken when the matching count is about to move on
    assign hit_a    = tick & (cnt_ff == COMPARE_A_VALUE);
    assign hit_b    = tick & (cnt_ff == COMPARE_B_VALUE);
    assign clr_now  = hit_a & clr_a_ff;
    assign wrap_evt = tick & ~clr_now
                      & (cnt_ff == `FRT_CNT_MAX);
    // Edge select: 1 rising, 0 falling
    assign cap_evt  = edge_ff ? (CAPTURE_INPUT_PIN & ~cap_q_ff)
                              : (~CAPTURE_INPUT_PIN & cap_q_ff);
    assign set_evt  = {cap_evt, hit_a, hit_b, wrap_evt};

    // Next counter and capture value
    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_cap = cap_ff;
        if (clr_now)
            nxt_cnt = `FRT_CNT_ZERO;
        else if (tick)
            nxt_cnt = cnt_ff + 16'h0001;
        if (cap_evt)
            nxt_cap = cnt_ff;
    end

    // Counter registers
    always_ff @(posedge CLOCK)
    begin
        if (rst_any)
        begin
            presc_ff  <= 7'h00;
            cnt_ff    <= `FRT_CNT_ZERO;
            cap_ff    <= `FRT_CNT_ZERO;
            strobe_ff <= 1'b0;
            ext_q_ff  <= 1'b0;
            cap_q_ff  <= 1'b0;
        end
        else
        begin
            presc_ff  <= nxt_presc;
            cnt_ff    <= nxt_cnt;
            cap_ff    <= nxt_cap;
            strobe_ff <= cap_evt;
            ext_q_ff  <= EXT_COUNT_PIN;
            cap_q_ff  <= CAPTURE_INPUT_PIN;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Register file
    ////////////////////////////////////////////////////////////////

    // Read views; reserved bits are constant
    assign en_view   = {en_ff[3], 3'b000, en_ff[2:0], 1'b1};
    assign stat_view = {flag_ff[3], 3'b000, flag_ff[2:0],
                        clr_a_ff};
    assign ce_view   = {edge_ff, 5'b0_0000, src_ff};
    assign wr_stat   = WR_EN & (ADDR == `FRT_OFS_CTRL_STAT);

    // Next register values
    always_comb
    begin
        nxt_en    = en_ff;
        nxt_clr_a = clr_a_ff;
        nxt_edge  = edge_ff;
        nxt_src   = src_ff;
        nxt_armed = armed_ff;
        nxt_rdata = rdata_ff;
        // Writes; fixed and reserved bits are dropped
        if (WR_EN && ADDR == `FRT_OFS_IRQ_EN)
            nxt_en = {WDATA[`FRT_BIT_CAPTURE], WDATA[`FRT_BIT_MATCH_A],
                      WDATA[`FRT_BIT_MATCH_B], WDATA[`FRT_BIT_WRAP]};
        if (wr_stat)
            nxt_clr_a = WDATA[`FRT_BIT_CLR_A];
        if (WR_EN && ADDR == `FRT_OFS_CLK_EDGE)
        begin
            nxt_edge = WDATA[`FRT_BIT_EDGE_SEL];
            nxt_src  = frt_pkg::frt_src_t'(
                       {WDATA[`FRT_BIT_CKS_HI], WDATA[`FRT_BIT_CKS_LO]});
        end
        // Any status write uses up the read-of-one
        if (wr_stat)
            nxt_armed = 4'h0;
        // Reads latch data; status reads arm set flags
        if (RD_EN)
        begin
            unique case (ADDR)
                `FRT_OFS_IRQ_EN:    nxt_rdata = en_view;
                `FRT_OFS_CTRL_STAT:
                begin
                    nxt_rdata = stat_view;
                    nxt_armed = nxt_armed | flag_ff;
                end
                `FRT_OFS_CLK_EDGE:  nxt_rdata = ce_view;
                default:            nxt_rdata = 8'h00;
            endcase
        end
    end

    // Flags: hardware set wins over a software clear
    always_comb
    begin
        nxt_flag = flag_ff;
        for (int i = 0; i < 4; i++)
        begin
            if (set_evt[i])
                nxt_flag[i] = 1'b1;
            else if (wr_stat && armed_ff[i] && !WDATA[i + 1 + (i / 3) * 3])
                nxt_flag[i] = 1'b0;
        end
    end

    // Register file storage
    always_ff @(posedge CLOCK)
    begin
        if (rst_any)
        begin
            en_ff    <= 4'h0;
            flag_ff  <= 4'h0;
            clr_a_ff <= 1'b0;
            armed_ff <= 4'h0;
            edge_ff  <= 1'b0;
            src_ff   <= frt_pkg::FRT_SRC_DIV8;
            rdata_ff <= 8'h00;
        end
        else
        begin
            en_ff    <= nxt_en;
            flag_ff  <= nxt_flag;
            clr_a_ff <= nxt_clr_a;
            armed_ff <= nxt_armed;
            edge_ff  <= nxt_edge;
            src_ff   <= nxt_src;
            rdata_ff <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////

    // Each request leaves on its own line; priority is decided outside
    assign IRQ.capture = flag_ff[3] & en_ff[3];
    assign IRQ.match_a = flag_ff[2] & en_ff[2];
    assign IRQ.match_b = flag_ff[1] & en_ff[1];
    assign IRQ.wrap    = flag_ff[0] & en_ff[0];
    assign RDATA          = rdata_ff;
    assign UP_COUNTER     = cnt_ff;
    assign CAPTURE_VALUE  = cap_ff;
    assign CAPTURE_STROBE = strobe_ff;

    ////////////////////////////////////////////////////////////////
    // Assertions
    ////////////////////////////////////////////////////////////////

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (rst_any);

    a_en_reset_val: assert property ($past(rst_any) |->
        en_view == `FRT_RST_IRQ_EN)
        else $error("enable view not 0x01 after reset");
    a_stat_reset_val: assert property ($past(rst_any) |->
        stat_view == `FRT_RST_CTRL_STAT)
        else $error("status not 0x00 after reset");
    a_ce_reset_val: assert property ($past(rst_any) |->
        ce_view == `FRT_RST_CLK_EDGE)
        else $error("clock/edge not 0x00 after reset");
    // Request lines checked against the bit places of the read views
    a_irq_gating: assert property (
        IRQ == {stat_view[7] & en_view[7], stat_view[3:1] & en_view[3:1]})
        else $error("request not flag and enable");
    // No flag may rise unless its own event fired the cycle before
    a_flag_hw_only: assert property (
        (flag_ff & ~$past(flag_ff) & ~$past(set_evt)) == 4'h0)
        else $error("flag set without hardware event");
    // A reset also drops the flag, so that edge is left out
    a_clear_needs_read: assert property (
        $fell(flag_ff[2]) && !$past(rst_any)
        |-> $past(wr_stat && armed_ff[2]))
        else $error("match A flag cleared without read");
    a_match_clear: assert property (clr_now |=>
        cnt_ff == `FRT_CNT_ZERO)
        else $error("counter not cleared on match A");
    a_count_step: assert property (tick && !clr_now |=>
        cnt_ff == $past(cnt_ff) + 16'h0001)
        else $error("counter did not step");
    a_capture_flag: assert property (cap_evt |=>
        flag_ff[3] && cap_ff == $past(cnt_ff))
        else $error("capture flag or value wrong");
    // Software may switch the source inside the window
    a_div8_period: assert property (
        src_ff == frt_pkg::FRT_SRC_DIV8 && tick
        |=> (!tick || src_ff != frt_pkg::FRT_SRC_DIV8) [*7])
        else $error("div8 tick too frequent");

    c_wrap: cover property (wrap_evt);
    c_capture_irq: cover property (IRQ.capture);
    c_read_then_clear: cover property ($fell(flag_ff[2]));

endmodule : frt_ctrl

// ---- tb/frt_cpu_model.sv ----
// CPU side model that drives the timer's byte register port
`timescale 1ns/10ps
`include "frt_consts.svh"
module frt_cpu_model (
    // Clock
    input  wire logic       CLOCK,
    // Byte register port
    output logic      [7:0] ADDR,
    output logic            WR_EN,
    output logic            RD_EN,
    output logic      [7:0] WDATA
);
    // Idle bus from time zero
    initial
    begin
        ADDR  = 8'h00;
        WR_EN = 1'b0;
        RD_EN = 1'b0;
        WDATA = 8'h00;
    end
    // One write; raw skips the fixed values software must use
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input bit raw = 0);
        logic [7:0] v;
        v = d;
        if (!raw && a == `FRT_OFS_IRQ_EN)
            v = (d & 8'h8e) | 8'h01;
        if (!raw && a == `FRT_OFS_CTRL_STAT)
            v = d & 8'h8f;
        if (!raw && a == `FRT_OFS_CLK_EDGE)
            v = d & 8'h83;
        @(negedge CLOCK);
        ADDR  <= a;
        WDATA <= v;
        WR_EN <= 1'b1;
        @(negedge CLOCK);
        WR_EN <= 1'b0;
        // Released data line no longer shows the old byte
        WDATA <= ~v;
    endtask : wr
    // One read; reading a set flag arms its clear
    task automatic rd(input logic [7:0] a);
        @(negedge CLOCK);
        ADDR  <= a;
        RD_EN <= 1'b1;
        @(negedge CLOCK);
        RD_EN <= 1'b0;
    endtask : rd
endmodule : frt_cpu_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the timer control and status block
`timescale 1ns/10ps
`include "frt_consts.svh"
module tb_top;
    localparam logic [7:0] oen = `FRT_OFS_IRQ_EN;
    localparam logic [7:0] ost = `FRT_OFS_CTRL_STAT;
    localparam logic [7:0] ock = `FRT_OFS_CLK_EDGE;
    // Design stimulus and results
    logic              clock = 1'b0;
    logic              srst = 1'b1;
    logic              stby = 1'b0;
    logic              mstby = 1'b0;
    logic [7:0]        addr, wdata, rdata;
    logic              wr_en, rd_en, cap_stb;
    logic [15:0]       cmp_a = 16'hffff;
    logic [15:0]       cmp_b = 16'hffff;
    logic              cap_pin = 1'b0;
    logic              ext_pin = 1'b0;
    logic [15:0]       cnt, cap_val, c0;
    frt_pkg::frt_irq_t irq;
    // Bookkeeping
    int                fail_count = 0;
    int                cmp_count = 0;
    int                nstb = 0;
    int                ca;
    logic [7:0]        v;
    logic [7:0]        exp_q[$];
    logic              rd_pend = 1'b0;
    // 200 MHz clock
    always #2.5 clock = ~clock;
    frt_ctrl dut_u (.CLOCK(clock), .SRST(srst), .STANDBY(stby),
        .MODULE_STANDBY(mstby), .ADDR(addr), .WR_EN(wr_en),
        .RD_EN(rd_en), .WDATA(wdata), .RDATA(rdata),
        .COMPARE_A_VALUE(cmp_a), .COMPARE_B_VALUE(cmp_b),
        .CAPTURE_INPUT_PIN(cap_pin), .EXT_COUNT_PIN(ext_pin),
        .UP_COUNTER(cnt), .CAPTURE_VALUE(cap_val),
        .CAPTURE_STROBE(cap_stb), .IRQ(irq));
    frt_cpu_model cpu_u (.CLOCK(clock), .ADDR(addr), .WR_EN(wr_en),
        .RD_EN(rd_en), .WDATA(wdata));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : chk
    // Note the expected byte, then read
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        cpu_u.rd(a);
    endtask : rd
    // Settled request lines at the next falling edge
    task automatic irqc(input logic [3:0] e);
        @(negedge clock);
        chk(irq === e, "irq lines");
    endtask : irqc
    // Pulses on the external count pin, wide enough to be seen
    task automatic tick(input int n);
        repeat (n)
        begin
            ext_pin <= 1'b1;
            repeat (6) @(negedge clock);
            ext_pin <= 1'b0;
            repeat (6) @(negedge clock);
        end
    endtask : tick
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    // Read data lands the cycle after the strobe
    always @(posedge clock) rd_pend <= rd_en;
    always @(negedge clock)
    begin
        if (cap_stb === 1'b1)
            nstb++;
        if (rd_pend)
        begin
            if (exp_q.size() == 0)
                chk(1'b0, "read without note");
            else
                chk(rdata === exp_q.pop_front(), "read data");
        end
    end
    // Watchdog, far beyond the roughly one thousand cycles needed
    initial
    begin
        #100000;
        fail_count++;
        summarize();
    end
    ////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(22820));
        repeat (8) @(negedge clock);
        srst <= 1'b0;
        rd(oen, `FRT_RST_IRQ_EN);
        rd(ost, `FRT_RST_CTRL_STAT);
        rd(ock, `FRT_RST_CLK_EDGE);
        rd(8'h12, 8'h00);
        cpu_u.wr(oen, 8'hff, 1);
        rd(oen, 8'h8f);
        cpu_u.wr(oen, 8'h00, 1);
        rd(oen, 8'h01);
        cpu_u.wr(ost, 8'hff, 1);
        rd(ost, 8'h01);
        cpu_u.wr(ock, 8'hff, 1);
        rd(ock, 8'h83);
        repeat (3)
        begin
            v = (8'($urandom) & 8'h8e) | 8'h01;
            cpu_u.wr(oen, v);
            rd(oen, v);
        end
        $display("test registers done");
        for (int s = 0; s < 2; s++)
        begin
            cpu_u.wr(oen, 8'h8f);
            cpu_u.wr(ost, 8'h01);
            cpu_u.wr(ock, 8'h83);
            stby <= (s == 0);
            mstby <= (s == 1);
            @(negedge clock);
            stby <= 1'b0;
            mstby <= 1'b0;
            chk(cnt === 16'h0000, "counter after standby");
            rd(oen, 8'h01);
            rd(ost, 8'h00);
            rd(ock, 8'h00);
        end
        $display("test standby done");
        // Random compare point, B two below A
        ca = 4 + $urandom % 6;
        cmp_a <= 16'(ca);
        cmp_b <= 16'(ca - 2);
        mstby <= 1'b1;
        @(negedge clock);
        mstby <= 1'b0;
        cpu_u.wr(ock, 8'h03);
        cpu_u.wr(oen, 8'h0c);
        cpu_u.wr(ost, 8'h01);
        tick(ca);
        chk(cnt === 16'(ca), "external count");
        irqc(4'b0010);
        tick(1);
        chk(cnt === 16'h0000, "clear on match");
        irqc(4'b0110);
        cpu_u.wr(ost, 8'h01);
        rd(ost, 8'h0d);
        cpu_u.wr(ost, 8'h01);
        rd(ost, 8'h01);
        irqc(4'b0000);
        cpu_u.wr(oen, 8'h01);
        cpu_u.wr(ost, 8'h00);
        tick(ca + 1);
        chk(cnt === 16'(ca + 1), "no clear");
        irqc(4'b0000);
        rd(ost, 8'h0c);
        cpu_u.wr(ost, 8'h00);
        rd(ost, 8'h00);
        $display("test compare done");
        cpu_u.wr(oen, 8'h81);
        cpu_u.wr(ock, 8'h83);
        cap_pin <= 1'b1;
        repeat (4) @(negedge clock);
        chk(cap_val === 16'(ca + 1), "captured value");
        irqc(4'b1000);
        rd(ost, 8'h80);
        cpu_u.wr(ost, 8'h00);
        cap_pin <= 1'b0;
        repeat (4) @(negedge clock);
        rd(ost, 8'h00);
        cpu_u.wr(ock, 8'h03);
        cap_pin <= 1'b1;
        repeat (4) @(negedge clock);
        cap_pin <= 1'b0;
        repeat (4) @(negedge clock);
        rd(ost, 8'h80);
        cpu_u.wr(oen, 8'h01);
        irqc(4'b0000);
        chk(nstb === 2, "capture strobes");
        $display("test capture done");
        for (int m = 0; m < 3; m++)
        begin
            cpu_u.wr(ock, 8'(m));
            repeat (2) @(negedge clock);
            c0 = cnt;
            repeat (32 << (2 * m)) @(negedge clock);
            chk(cnt - c0 === 16'h0004, "divided rate");
        end
        $display("test rates done");
        summarize();
    end
endmodule : tb_top
